//--- reset_source_controller.sv
// Reset source combiner, reset stretcher and cause register
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "reset_source_regs.svh"

module reset_source_controller
  import reset_source_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Reset sources
  input wire logic poweron_low,
  input wire logic ext_rst_pin_n,
  input wire logic brownout_below,
  input wire logic wdog_expire,
  input wire logic wdog_enable,
  input wire logic wdog_int_enable,
  // Fuses
  input fuse_s fuses,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_r,
  // Reset and reference outputs
  output logic sys_reset_r,
  output logic fetch_start_r,
  output logic bandgap_en_r,
  output logic brownout_enable_r,
  output logic [1:0] brownout_level_sel_r
);

  // ****************************************************************
  // Fuse decoding
  // ****************************************************************

  // Reserved codes leave detection off
  function automatic logic brownout_on(input logic [2:0] lvl);
    return (lvl == `BROWNOUT_FUSE_LOW) || (lvl == `BROWNOUT_FUSE_MID) ||
      (lvl == `BROWNOUT_FUSE_HIGH);
  endfunction

  function automatic logic [1:0] brownout_sel(input logic [2:0] lvl);
    logic [1:0] sel;
    sel = 2'h0;
    case (lvl)
      `BROWNOUT_FUSE_LOW: sel = 2'h1;
      `BROWNOUT_FUSE_MID: sel = 2'h2;
      `BROWNOUT_FUSE_HIGH: sel = 2'h3;
      default: sel = 2'h0;
    endcase
    return sel;
  endfunction

  // An external clock needs no oscillator settling
  function automatic delay_t delay_len(input logic [1:0] st, input logic [3:0] cs);
    delay_t len;
    len = `DELAY_STARTUP0;
    if (cs == `CLKSEL_EXTCLK)
      len = `DELAY_EXTCLK;
    else
    begin
      case (st)
        2'h0: len = `DELAY_STARTUP0;
        2'h1: len = `DELAY_STARTUP1;
        2'h2: len = `DELAY_STARTUP2;
        default: len = `DELAY_STARTUP3;
      endcase
    end
    return len;
  endfunction

  // ****************************************************************
  // Reset sources
  // ****************************************************************

  logic wdog_fire;
  logic wdog_fire_d_r;
  logic wdog_pulse_r;
  logic brownout_active;
  reset_src_s src;
  logic src_any;

  assign wdog_fire = wdog_expire && wdog_enable && !wdog_int_enable;

  // One pulse per expiry even if the expiry input lingers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wdog_fire_d_r <= 1'b0;
      wdog_pulse_r <= 1'b0;
    end
    else
    begin
      wdog_fire_d_r <= wdog_fire;
      wdog_pulse_r <= wdog_fire && !wdog_fire_d_r;
    end
  end

  assign brownout_active = brownout_on(fuses.brownout_level_fuses) && brownout_below;

  assign src.poweron = poweron_low;
  assign src.pin = !ext_rst_pin_n;
  assign src.wdog = wdog_pulse_r;
  assign src.brownout = brownout_active;
  assign src_any = |src;

  // ****************************************************************
  // Reset sequencing
  // ****************************************************************

  seq_state_e state_r;
  logic tmr_expired;
  logic release_now;

  assign release_now = (state_r == ST_STRETCH) && tmr_expired && !src_any;

  // Timer reloads in hold, so it starts on the second clear cycle, after ST_HOLD is left
  stretch_timer u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hold(src_any || (state_r == ST_HOLD)),
    .load_val(delay_len(fuses.startup_time_fuses, fuses.clock_select_fuses)),
    .expired(tmr_expired)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_r <= ST_HOLD;
    else
    begin
      case (state_r)
        ST_HOLD:
        begin
          if (!src_any)
            state_r <= ST_STRETCH;
        end
        ST_STRETCH:
        begin
          if (src_any)
            state_r <= ST_HOLD;
          else if (tmr_expired)
            state_r <= ST_RUN;
        end
        ST_RUN:
        begin
          // A glitch caught only by the async set must still be stretched
          if (src_any || sys_reset_r)
            state_r <= ST_HOLD;
        end
        default: state_r <= ST_HOLD;
      endcase
    end
  end

  // Async set works with the clock stopped; release is clocked
  always_ff @(posedge core_clk or posedge src_any)
  begin
    if (src_any)
      sys_reset_r <= 1'b1;
    else if (!rst_n)
      sys_reset_r <= 1'b1;
    else if (release_now)
      sys_reset_r <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      fetch_start_r <= 1'b0;
    else
      fetch_start_r <= release_now;
  end

  // ****************************************************************
  // Cause flags and comparator control
  // ****************************************************************

  logic [3:0] flags;
  logic flags_wr;
  logic cmpctl_wr;
  logic bg_sel_r;

  assign flags_wr = reg_wr && (reg_addr == `FLAGS_ADDR);
  assign cmpctl_wr = reg_wr && (reg_addr == `CMPCTL_ADDR);

  cause_flags u_flags (
    .core_clk(core_clk),
    .set_src(src),
    .wr_en(flags_wr),
    .wr_data(reg_wdata[3:0]),
    .flags_r(flags)
  );

  // An I/O register: back to its initial value while in reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || sys_reset_r)
      bg_sel_r <= `CMPCTL_RESET;
    else if (cmpctl_wr)
      bg_sel_r <= reg_wdata[`BG_SEL_BIT];
  end

  // Read data stands only in the cycle after each cycle with reg_rd high
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !reg_rd)
      reg_rdata_r <= 8'h00;
    else
    begin
      case (reg_addr)
        `FLAGS_ADDR: reg_rdata_r <= {4'h0, flags};
        `CMPCTL_ADDR: reg_rdata_r <= 8'(bg_sel_r) << `BG_SEL_BIT;
        default: reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Reference and detector control
  // ****************************************************************

  // Reference start-up time is software's to wait out
  always_ff @(posedge core_clk)
  begin
    bandgap_en_r <= brownout_on(fuses.brownout_level_fuses) || bg_sel_r;
    brownout_enable_r <= brownout_on(fuses.brownout_level_fuses);
    brownout_level_sel_r <= brownout_sel(fuses.brownout_level_fuses);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  logic [12:0] hold_cyc_r;

  // Counts clear cycles spent stretching, for the release timing check
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || src_any || !sys_reset_r)
      hold_cyc_r <= 13'h0000;
    else
      hold_cyc_r <= hold_cyc_r + 13'h0001;
  end

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (!rst_n);

  src_reset_a: assert property (
    src_any |=> sys_reset_r
  ) else $error("reset source did not assert reset");

  stretch_hold_a: assert property (
    (state_r == ST_STRETCH) |-> sys_reset_r
  ) else $error("reset released while stretching");

  release_time_a: assert property (
    $fell(sys_reset_r) |->
      hold_cyc_r == ({1'b0, delay_len(fuses.startup_time_fuses,
        fuses.clock_select_fuses)} + 13'h0002)
  ) else $error("reset stretched by wrong delay");

  wdog_gate_a: assert property (
    $rose(wdog_fire) |=> wdog_pulse_r
  ) else $error("gated watchdog expiry gave no pulse");

  wdog_block_a: assert property (
    (wdog_int_enable || !wdog_enable) |=> !wdog_pulse_r
  ) else $error("watchdog reset despite gating");

  wdog_pulse_a: assert property (
    wdog_pulse_r |=> !wdog_pulse_r ##1 sys_reset_r
  ) else $error("watchdog pulse longer than one cycle");

  poweron_flags_a: assert property (
    poweron_low |=> sys_reset_r && flags[`POWERON_FLAG_BIT] &&
      flags[`WDOG_FLAG_BIT:`PIN_FLAG_BIT] == 3'h0
  ) else $error("power-on did not reset and mark flags");

  pin_reset_a: assert property (
    !ext_rst_pin_n |=> sys_reset_r && flags[`PIN_FLAG_BIT]
  ) else $error("pin reset missed");

  brownout_reset_a: assert property (
    brownout_active && !poweron_low |=> sys_reset_r && flags[`BROWNOUT_FLAG_BIT]
  ) else $error("brown-out reset missed");

  brownout_off_a: assert property (
    (fuses.brownout_level_fuses[2] == 1'b0) |=> !brownout_enable_r
  ) else $error("reserved brown-out code enabled detection");

  wdog_clear_a: assert property (
    flags_wr && !reg_wdata[`WDOG_FLAG_BIT] && !wdog_pulse_r && !poweron_low
      |=> !flags[`WDOG_FLAG_BIT]
  ) else $error("watchdog flag not cleared by write");

  flag_keep_a: assert property (
    flags[`POWERON_FLAG_BIT] && !flags_wr |=> flags[`POWERON_FLAG_BIT]
  ) else $error("power-on flag lost without a write");

  upper_zero_a: assert property (
    reg_rd && (reg_addr == `FLAGS_ADDR) |=> reg_rdata_r[7:4] == 4'h0 &&
      reg_rdata_r[3:0] == $past(flags)
  ) else $error("flag read data wrong");

  bandgap_off_a: assert property (
    (!brownout_on(fuses.brownout_level_fuses) && !bg_sel_r) [*2] |-> !bandgap_en_r
  ) else $error("bandgap on with no user");

  fetch_start_a: assert property (
    fetch_start_r |-> !sys_reset_r && $past(sys_reset_r)
  ) else $error("fetch start not at reset release");

  io_init_a: assert property (
    sys_reset_r |=> !bg_sel_r
  ) else $error("I/O register kept value through reset");

endmodule // reset_source_controller

//--- reset_source_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RESET_SOURCE_REGS_SVH
`define RESET_SOURCE_REGS_SVH

`define FLAGS_ADDR 8'h00
`define CMPCTL_ADDR 8'h01

`define WDOG_FLAG_BIT 3
`define BROWNOUT_FLAG_BIT 2
`define PIN_FLAG_BIT 1
`define POWERON_FLAG_BIT 0
`define BG_SEL_BIT 0

`define CMPCTL_RESET 1'b0

`define BROWNOUT_FUSE_OFF 3'h7
`define BROWNOUT_FUSE_LOW 3'h6
`define BROWNOUT_FUSE_MID 3'h5
`define BROWNOUT_FUSE_HIGH 3'h4

`define DELAY_STARTUP0 12'h008
`define DELAY_STARTUP1 12'h040
`define DELAY_STARTUP2 12'h200
`define DELAY_STARTUP3 12'hfff
`define DELAY_EXTCLK 12'h002
`define CLKSEL_EXTCLK 4'h0

`define BG_START_US 70

`endif

//--- reset_source_pkg.sv
// Types shared by the reset source controller files
package reset_source_pkg;

  typedef struct packed {
    logic poweron;
    logic pin;
    logic wdog;
    logic brownout;
  } reset_src_s;

  typedef struct packed {
    logic [2:0] brownout_level_fuses;
    logic [1:0] startup_time_fuses;
    logic [3:0] clock_select_fuses;
  } fuse_s;

  typedef logic [11:0] delay_t;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_STRETCH,
    ST_RUN
  } seq_state_e;

endpackage

//--- stretch_timer.sv
// Delay counter that stretches the internal reset
`timescale 1ns/1ps
module stretch_timer
  import reset_source_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic hold,
  input delay_t load_val,
  // Status
  output logic expired
);

  delay_t cnt_r;

  // Reloaded while held, so every release restarts the full delay
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || hold)
      cnt_r <= load_val;
    else if (cnt_r != 12'h000)
      cnt_r <= cnt_r - 12'h001;
  end

  assign expired = (cnt_r == 12'h000) && !hold;

endmodule // stretch_timer

//--- cause_flags.sv
// Sticky reset cause flags
`timescale 1ns/1ps
module cause_flags
  import reset_source_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Causes
  input reset_src_s set_src,
  // Software write
  input wire logic wr_en,
  input wire logic [3:0] wr_data,
  // Flags
  output logic [3:0] flags_r
);

  // Set wins over a software clear in the same cycle
  function automatic logic next_flag(input logic cur, input logic set, input logic clr);
    return set || (cur && !clr);
  endfunction

  // No reset input: a power-on event, a set by a cause or a clearing write defines these
  always_ff @(posedge core_clk)
  begin
    if (set_src.poweron)
    begin
      flags_r[`WDOG_FLAG_BIT] <= 1'b0;
      flags_r[`BROWNOUT_FLAG_BIT] <= 1'b0;
      flags_r[`PIN_FLAG_BIT] <= 1'b0;
    end
    else
    begin
      flags_r[`WDOG_FLAG_BIT] <= next_flag(flags_r[`WDOG_FLAG_BIT], set_src.wdog,
        wr_en && !wr_data[`WDOG_FLAG_BIT]);
      flags_r[`BROWNOUT_FLAG_BIT] <= next_flag(flags_r[`BROWNOUT_FLAG_BIT],
        set_src.brownout, wr_en && !wr_data[`BROWNOUT_FLAG_BIT]);
      flags_r[`PIN_FLAG_BIT] <= next_flag(flags_r[`PIN_FLAG_BIT], set_src.pin,
        wr_en && !wr_data[`PIN_FLAG_BIT]);
    end
    flags_r[`POWERON_FLAG_BIT] <= next_flag(flags_r[`POWERON_FLAG_BIT], set_src.poweron,
      wr_en && !wr_data[`POWERON_FLAG_BIT]);
  end

endmodule // cause_flags

//--- reset_src_model.sv
// Model of the reset pin, supply detectors and watchdog
`timescale 1ns/1ps
module reset_src_model (
  // Clock
  input wire logic core_clk,
  // Source levels
  output logic poweron_low,
  output logic ext_rst_pin_n,
  output logic brownout_below,
  // Watchdog
  output logic wdog_expire,
  output logic wdog_enable,
  output logic wdog_int_enable
);
  // Supply starts low so the cause flags come up defined
  initial
  begin
    poweron_low = 1'b1;
    ext_rst_pin_n = 1'b1;
    brownout_below = 1'b0;
    wdog_expire = 1'b0;
    wdog_enable = 1'b0;
    wdog_int_enable = 1'b0;
  end

  // 0 supply low, 1 pin low, else supply below brown-out level
  task automatic set_src(input int which);
    @(posedge core_clk);
    // Other sources keep their level
    poweron_low <= poweron_low || (which == 0);
    ext_rst_pin_n <= ext_rst_pin_n && (which != 1);
    brownout_below <= brownout_below || (which > 1);
  endtask

  task automatic release_all();
    @(posedge core_clk);
    poweron_low <= 1'b0;
    ext_rst_pin_n <= 1'b1;
    brownout_below <= 1'b0;
  endtask

  // Expiry held one cycle; enables settle a cycle before it
  task automatic wdog_tick(input logic en, input logic int_en);
    @(posedge core_clk);
    wdog_enable <= en;
    wdog_int_enable <= int_en;
    @(posedge core_clk);
    wdog_expire <= 1'b1;
    @(posedge core_clk);
    wdog_expire <= 1'b0;
  endtask
endmodule // reset_src_model

//--- tb.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`include "reset_source_regs.svh"
module tb
  import reset_source_pkg::*;
;
  logic core_clk, rst_n, poweron_low, ext_rst_pin_n, brownout_below;
  logic wdog_expire, wdog_enable, wdog_int_enable, reg_wr, reg_rd;
  logic sys_reset_r, fetch_start_r, bandgap_en_r, brownout_enable_r;
  logic [1:0] brownout_level_sel_r;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r;
  fuse_s fuses;
  int errors, cmp_count, n;

  always #50 core_clk = ~core_clk;

  reset_src_model u_src (.core_clk(core_clk), .poweron_low(poweron_low),
    .ext_rst_pin_n(ext_rst_pin_n), .brownout_below(brownout_below),
    .wdog_expire(wdog_expire), .wdog_enable(wdog_enable), .wdog_int_enable(wdog_int_enable));

  reset_source_controller u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .poweron_low(poweron_low), .ext_rst_pin_n(ext_rst_pin_n),
    .brownout_below(brownout_below), .wdog_expire(wdog_expire),
    .wdog_enable(wdog_enable), .wdog_int_enable(wdog_int_enable), .fuses(fuses),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .sys_reset_r(sys_reset_r), .fetch_start_r(fetch_start_r),
    .bandgap_en_r(bandgap_en_r), .brownout_enable_r(brownout_enable_r),
    .brownout_level_sel_r(brownout_level_sel_r));

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h0, got}, {7'h0, exp}, what);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata_r, exp, "read data");
  endtask

  // Edges from source release until reset drops; exp 0 skips the count
  task automatic wait_rel(input int exp);
    n = 0;
    while (sys_reset_r !== 1'b0 && n < 5000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 5000)
    begin
      errors++;
      $display("ERROR %0t reset never released", $time);
      summarize();
    end
    chk1(fetch_start_r, 1'b1, "fetch start");
    if (exp > 0)
      chk8(8'(n), 8'(exp), "stretch length");
  endtask

  task automatic tend(input string s);
    $display("Test %s finished", s);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    fuses = 9'h1c0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    u_src.release_all();
    wait_rel(`DELAY_EXTCLK + 2);
    rd(`FLAGS_ADDR, 8'h01);
    tend("power-on");
    u_src.set_src(1);
    #10;
    chk1(sys_reset_r, 1'b1, "pin reset");
    repeat (3) @(posedge core_clk);
    u_src.release_all();
    wait_rel(`DELAY_EXTCLK + 2);
    rd(`FLAGS_ADDR, 8'h03);
    wr(`FLAGS_ADDR, 8'h00);
    rd(`FLAGS_ADDR, 8'h00);
    tend("pin");
    // Every code keeps startup 0 on a non-external clock, which selects the 8-cycle stretch
    for (int c = 0; c < 8; c++)
    begin
      @(posedge core_clk);
      fuses <= {c[2:0], 2'h0, 4'h1};
      repeat (2) @(posedge core_clk);
      #1;
      chk1(brownout_enable_r, c inside {[4:6]}, "detect enable");
      chk8({6'h0, brownout_level_sel_r}, (c inside {[4:6]}) ? 8'(7 - c) : 8'h00, "level");
      chk1(bandgap_en_r, c inside {[4:6]}, "bandgap");
    end
    u_src.set_src(2);
    repeat (3) @(posedge core_clk);
    #1;
    chk1(sys_reset_r, 1'b0, "detect off");
    u_src.release_all();
    fuses <= 9'h141;
    repeat (2) @(posedge core_clk);
    u_src.set_src(2);
    #10;
    chk1(sys_reset_r, 1'b1, "brown-out reset");
    repeat (2) @(posedge core_clk);
    u_src.release_all();
    wait_rel(`DELAY_STARTUP0 + 2);
    rd(`FLAGS_ADDR, 8'h04);
    tend("brown-out");
    u_src.set_src(1);
    repeat (2) @(posedge core_clk);
    u_src.release_all();
    repeat (4) @(posedge core_clk);
    u_src.set_src(1);
    u_src.release_all();
    wait_rel(`DELAY_STARTUP0 + 2);
    rd(`FLAGS_ADDR, 8'h06);
    tend("restart");
    u_src.wdog_tick(1'b1, 1'b1);
    #1;
    chk1(sys_reset_r, 1'b0, "watchdog interrupt mode");
    u_src.wdog_tick(1'b0, 1'b0);
    #1;
    chk1(sys_reset_r, 1'b0, "watchdog off");
    u_src.wdog_tick(1'b1, 1'b0);
    #1;
    chk1(sys_reset_r, 1'b1, "watchdog reset");
    // One edge for the pulse to fall, then the usual stretch
    wait_rel(`DELAY_STARTUP0 + 3);
    rd(`FLAGS_ADDR, 8'h0e);
    u_src.set_src(0);
    repeat (2) @(posedge core_clk);
    u_src.release_all();
    wait_rel(`DELAY_STARTUP0 + 2);
    rd(`FLAGS_ADDR, 8'h01);
    wr(`FLAGS_ADDR, 8'hf1);
    rd(`FLAGS_ADDR, 8'h01);
    wr(`FLAGS_ADDR, 8'h00);
    rd(`FLAGS_ADDR, 8'h00);
    tend("watchdog and flags");
    @(posedge core_clk);
    fuses <= 9'h1c0;
    wr(`CMPCTL_ADDR, 8'h01);
    repeat (2) @(posedge core_clk);
    #1;
    chk1(bandgap_en_r, 1'b1, "bandgap select");
    // Reference start-up before the comparator is trusted
    repeat (`BG_START_US * 10) @(posedge core_clk);
    rd(`CMPCTL_ADDR, 8'h01);
    rd(8'h05, 8'h00);
    wr(8'h05, 8'hff);
    rd(`FLAGS_ADDR, 8'h00);
    u_src.set_src(1);
    repeat (2) @(posedge core_clk);
    u_src.release_all();
    wait_rel(`DELAY_EXTCLK + 2);
    rd(`CMPCTL_ADDR, 8'h00);
    chk1(bandgap_en_r, 1'b0, "bandgap off");
    tend("bandgap");
    summarize();
  end
endmodule // tb
